// >>> logic/uhis_top.sv
`include "uhis_defines.svh"

module uhis_top #(
    parameter bit SMI_PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 RST_IN,
    // Register access port
    input  wire uhis_pkg::uhis_addr_t REG_ADDR_IN,
    input  wire logic                 REG_WR_IN,
    input  wire uhis_pkg::uhis_word_t REG_WDATA_IN,
    input  wire logic                 REG_RD_IN,
    output uhis_pkg::uhis_word_t      REG_RDATA_OUT,
    // Event sources on the controller clock
    input  wire logic                 ROOT_CHANGE_IN,
    input  wire logic                 FRAME_MSB_IN,
    input  wire logic                 SHARED_FRAME_UPD_IN,
    input  wire logic                 SYS_ERROR_IN,
    input  wire logic                 RESUME_SIG_IN,
    input  wire logic                 RESUME_STATE_IN,
    input  wire logic                 SOF_TOKEN_IN,
    input  wire logic                 DONE_WB_IN,
    input  wire logic                 SCHED_OVERRUN_IN,
    input  wire logic                 OWN_CHANGE_DONE_IN,
    // Requests and controls
    output logic                      IRQ_OUT,
    output logic                      SMI_OUT,
    output logic                      HALT_OUT,
    output logic                      DONE_WB_ALLOW_OUT,
    output logic                      OWN_REQ_OUT,
    output logic [1:0]                OVERRUN_COUNT_OUT
);
    import uhis_pkg::*;

    // --------------------------------------------------------------
    // Local state.
    // --------------------------------------------------------------
    uhis_word_t     status_q;
    uhis_word_t     status_d;
    uhis_word_t     enable_q;
    uhis_word_t     set_vec;
    uhis_word_t     clr_vec;
    uhis_word_t     rdata_d;
    logic           own_req_q;
    logic           frame_ovf_pend_q;
    logic           sched_ovr_pend_q;
    logic           wr_status;
    logic           wr_enable;
    logic           wr_disable;
    logic           wr_cmd;
    logic           own_req_set;
    logic           frame_toggle;
    logic           resume_rise;
    logic           frame_ovf_set;
    logic           sched_ovr_set;
    logic           qualified;
    uhis_wb_state_t wb_state_q;
    uhis_wb_state_t wb_state_d;
    logic [1:0]     soc_count;

    // --------------------------------------------------------------
    // Helper functions.
    // --------------------------------------------------------------

    // Address match for a write strobe.
    function automatic logic hit(input uhis_addr_t addr,
                                 input uhis_addr_t ofs);
        hit = (addr == ofs);
    endfunction : hit

    // One-hot word with a single bit raised.
    function automatic uhis_word_t bit_word(input int pos,
                                            input logic val);
        uhis_word_t w;
        w = `UHIS_RESET_WORD;
        w[pos] = val;
        bit_word = w;
    endfunction : bit_word

    // --------------------------------------------------------------
    // Edge detectors for level sources.
    // --------------------------------------------------------------
    uhis_edge_if resume_if ();
    uhis_edge_if frame_if ();

    assign resume_if.level = RESUME_SIG_IN;
    assign frame_if.level  = FRAME_MSB_IN;

    uhis_edge_det u_resume_edge (
        .clk_in  (MCLK_IN),
        .rst_in  (RST_IN),
        .edge_io (resume_if.det)
    );

    uhis_edge_det u_frame_edge (
        .clk_in  (MCLK_IN),
        .rst_in  (RST_IN),
        .edge_io (frame_if.det)
    );

    // A resume that software itself started is not a detection.
    assign resume_rise  = resume_if.rise & ~RESUME_STATE_IN;
    assign frame_toggle = frame_if.toggle;

    // --------------------------------------------------------------
    // Overrun counter.
    // --------------------------------------------------------------

    // Counts each overrun even with the flag already set.
    uhis_wrap_cnt #(
        .WIDTH (`UHIS_SOC_WIDTH)
    ) u_overrun_cnt (
        .clk_in    (MCLK_IN),
        .rst_in    (RST_IN),
        .inc_in    (SCHED_OVERRUN_IN),
        .count_out (soc_count)
    );

    // --------------------------------------------------------------
    // Register write decode.
    // --------------------------------------------------------------

    // Writes to unmapped offsets are dropped with no side effect.
    assign wr_status  = REG_WR_IN & hit(REG_ADDR_IN, `UHIS_OFS_EVT_STATUS);
    assign wr_enable  = REG_WR_IN & hit(REG_ADDR_IN, `UHIS_OFS_IRQ_ENABLE);
    assign wr_disable = REG_WR_IN & hit(REG_ADDR_IN, `UHIS_OFS_IRQ_DISABLE);
    assign wr_cmd     = REG_WR_IN & hit(REG_ADDR_IN, `UHIS_OFS_CMD_STATUS);

    // Reserved positions are masked so stray ones have no effect.
    assign clr_vec = wr_status ? (REG_WDATA_IN & `UHIS_STATUS_MASK)
                               : `UHIS_RESET_WORD;

    // Software can only raise the request, never drop it.
    assign own_req_set = wr_cmd & REG_WDATA_IN[`UHIS_BIT_OWN_REQ];

    // --------------------------------------------------------------
    // Ownership request bit.
    // --------------------------------------------------------------

    // Held until the changeover logic reports completion.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            own_req_q <= 1'b0;
        end else if (own_req_set) begin
            own_req_q <= 1'b1;
        end else if (OWN_CHANGE_DONE_IN) begin
            own_req_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Deferred frame events.
    // --------------------------------------------------------------

    // Overflow and overrun wait for the shared frame number update,
    // so software sees the new frame number before the flag.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            frame_ovf_pend_q <= 1'b0;
        end else if (SHARED_FRAME_UPD_IN) begin
            frame_ovf_pend_q <= 1'b0;
        end else if (frame_toggle) begin
            frame_ovf_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sched_ovr_pend_q <= 1'b0;
        end else if (SHARED_FRAME_UPD_IN) begin
            sched_ovr_pend_q <= 1'b0;
        end else if (SCHED_OVERRUN_IN) begin
            sched_ovr_pend_q <= 1'b1;
        end
    end

    // Same-cycle event and update still counts.
    assign frame_ovf_set = SHARED_FRAME_UPD_IN &
                           (frame_ovf_pend_q | frame_toggle);
    assign sched_ovr_set = SHARED_FRAME_UPD_IN &
                           (sched_ovr_pend_q | SCHED_OVERRUN_IN);

    // --------------------------------------------------------------
    // Event set vector.
    // --------------------------------------------------------------
    always_comb begin
        set_vec = `UHIS_RESET_WORD;
        // Forced to zero when the management pin is absent.
        set_vec = set_vec | bit_word(`UHIS_BIT_OWN_CHANGE,
                                     own_req_set & SMI_PRESENT);
        set_vec = set_vec | bit_word(`UHIS_BIT_ROOT_PORT,
                                     ROOT_CHANGE_IN);
        set_vec = set_vec | bit_word(`UHIS_BIT_FRAME_OVF,
                                     frame_ovf_set);
        set_vec = set_vec | bit_word(`UHIS_BIT_FATAL_ERR,
                                     SYS_ERROR_IN);
        set_vec = set_vec | bit_word(`UHIS_BIT_RESUME,
                                     resume_rise);
        set_vec = set_vec | bit_word(`UHIS_BIT_FRAME_START,
                                     SOF_TOKEN_IN);
        set_vec = set_vec | bit_word(`UHIS_BIT_DONE_WB,
                                     DONE_WB_IN);
        set_vec = set_vec | bit_word(`UHIS_BIT_SCHED_OVR,
                                     sched_ovr_set);
    end

    // --------------------------------------------------------------
    // Event status register.
    // --------------------------------------------------------------

    // Set wins over a clear in the same cycle so no event is lost.
    // Nothing but RST_IN or a software write-one removes a flag.
    assign status_d = ((status_q & ~clr_vec) | set_vec) &
                      `UHIS_STATUS_MASK;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            status_q <= `UHIS_RESET_WORD;
        end else begin
            status_q <= status_d;
        end
    end

    // --------------------------------------------------------------
    // Interrupt enable register.
    // --------------------------------------------------------------

    // Set-by-one at one offset, clear-by-one at the other.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            enable_q <= `UHIS_RESET_WORD;
        end else if (wr_enable) begin
            enable_q <= enable_q | (REG_WDATA_IN & `UHIS_ENABLE_MASK);
        end else if (wr_disable) begin
            enable_q <= enable_q & ~(REG_WDATA_IN & `UHIS_ENABLE_MASK);
        end
    end

    // --------------------------------------------------------------
    // Interrupt outputs.
    // --------------------------------------------------------------

    // Uses the next status so a cleared flag drops the request on
    // the following edge rather than two edges later.
    assign qualified = enable_q[`UHIS_BIT_GLOBAL_EN] &
                       (|(status_d & enable_q & `UHIS_STATUS_MASK));

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= qualified;
        end
    end

    // The management interrupt ignores the global enable.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SMI_OUT <= 1'b0;
        end else begin
            SMI_OUT <= SMI_PRESENT &
                       status_d[`UHIS_BIT_OWN_CHANGE] &
                       enable_q[`UHIS_BIT_OWN_CHANGE];
        end
    end

    // --------------------------------------------------------------
    // Fatal error halt.
    // --------------------------------------------------------------

    // Halt follows the flag; it lifts only on RST_IN or when software clears it,
    // which software does after resetting the controller.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            HALT_OUT <= 1'b0;
        end else begin
            HALT_OUT <= status_d[`UHIS_BIT_FATAL_ERR];
        end
    end

    // --------------------------------------------------------------
    // Done-head writeback gate.
    // --------------------------------------------------------------

    // Once a writeback lands the path stays shut until the flag is
    // gone; the list engine must check the allow output first.
    always_comb begin
        wb_state_d = wb_state_q;
        case (wb_state_q)
            UHIS_WB_OPEN: begin
                if (DONE_WB_IN) begin
                    wb_state_d = UHIS_WB_HELD;
                end
            end
            UHIS_WB_HELD: begin
                if (!status_d[`UHIS_BIT_DONE_WB]) begin
                    wb_state_d = UHIS_WB_OPEN;
                end
            end
            default: begin
                wb_state_d = UHIS_WB_OPEN;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wb_state_q <= UHIS_WB_OPEN;
        end else begin
            wb_state_q <= wb_state_d;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            DONE_WB_ALLOW_OUT <= 1'b1;
        end else begin
            DONE_WB_ALLOW_OUT <= (wb_state_d == UHIS_WB_OPEN);
        end
    end

    // --------------------------------------------------------------
    // Command status mirrors.
    // --------------------------------------------------------------
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            OWN_REQ_OUT       <= 1'b0;
            OVERRUN_COUNT_OUT <= 2'h0;
        end else begin
            OWN_REQ_OUT       <= own_req_q;
            OVERRUN_COUNT_OUT <= soc_count;
        end
    end

    // --------------------------------------------------------------
    // Register read path.
    // --------------------------------------------------------------

    // Only bits this block owns read back; others read as zero.
    always_comb begin
        rdata_d = `UHIS_RESET_WORD;
        case (REG_ADDR_IN)
            `UHIS_OFS_EVT_STATUS: begin
                rdata_d = status_q;
            end
            `UHIS_OFS_IRQ_ENABLE,
            `UHIS_OFS_IRQ_DISABLE: begin
                rdata_d = enable_q;
            end
            `UHIS_OFS_CMD_STATUS: begin
                rdata_d[`UHIS_BIT_OWN_REQ] = own_req_q;
                rdata_d[`UHIS_SOC_LSB +: `UHIS_SOC_WIDTH] = soc_count;
            end
            default: begin
                rdata_d = `UHIS_RESET_WORD;
            end
        endcase
    end

    // Read data lands one edge after the strobe and then holds.
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= `UHIS_RESET_WORD;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= rdata_d;
        end
    end

endmodule : uhis_top

// >>> inc/uhis_defines.svh
`ifndef UHIS_DEFINES_SVH
`define UHIS_DEFINES_SVH

// --------------------------------------------------------------
// Register offsets (byte addresses in the operational window).
// --------------------------------------------------------------
`define UHIS_OFS_CMD_STATUS   8'h08
`define UHIS_OFS_EVT_STATUS   8'h0C
`define UHIS_OFS_IRQ_ENABLE   8'h10
`define UHIS_OFS_IRQ_DISABLE  8'h14

// --------------------------------------------------------------
// Field positions.
// --------------------------------------------------------------
`define UHIS_BIT_GLOBAL_EN    31
`define UHIS_BIT_OWN_CHANGE   30
`define UHIS_BIT_ROOT_PORT    6
`define UHIS_BIT_FRAME_OVF    5
`define UHIS_BIT_FATAL_ERR    4
`define UHIS_BIT_RESUME       3
`define UHIS_BIT_FRAME_START  2
`define UHIS_BIT_DONE_WB      1
`define UHIS_BIT_SCHED_OVR    0
`define UHIS_BIT_OWN_REQ      3
`define UHIS_SOC_LSB          16
`define UHIS_SOC_WIDTH        2

// --------------------------------------------------------------
// Reset values and implemented-bit masks.
// --------------------------------------------------------------
`define UHIS_RESET_WORD       32'h0000_0000
`define UHIS_STATUS_MASK      32'h4000_007F
`define UHIS_ENABLE_MASK      32'hC000_007F

`endif

// >>> inc/uhis_pkg.sv
package uhis_pkg;

    // --------------------------------------------------------------
    // Shared types.
    // --------------------------------------------------------------
    typedef logic [31:0] uhis_word_t;
    typedef logic [7:0]  uhis_addr_t;

    // Gate for the done-head writeback path.
    typedef enum logic [0:0] {
        UHIS_WB_OPEN,
        UHIS_WB_HELD
    } uhis_wb_state_t;

endpackage : uhis_pkg

// >>> inc/uhis_edge_if.sv
// Carries one level into a detector and its edge pulses back.
interface uhis_edge_if;
    logic level;
    logic rise;
    logic toggle;

    modport det (input level, output rise, output toggle);
    modport src (output level, input rise, input toggle);
endinterface : uhis_edge_if

// >>> logic/uhis_edge_det.sv
// Edge detector on a same-clock level; pulses are one cycle wide.
module uhis_edge_det (
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    // Level in, edges out
    uhis_edge_if.det   edge_io
);
    logic prev_q;

    // --------------------------------------------------------------
    // Previous level; reset to low so a level high out of reset
    // counts as a rising edge.
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= edge_io.level;
        end
    end

    // Edge decode.
    assign edge_io.rise   = edge_io.level & ~prev_q;
    assign edge_io.toggle = edge_io.level ^ prev_q;

endmodule : uhis_edge_det

// >>> logic/uhis_wrap_cnt.sv
// Small counter that wraps from all ones back to zero.
module uhis_wrap_cnt #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Count control
    input  wire logic             inc_in,
    output logic [WIDTH-1:0]      count_out
);
    // --------------------------------------------------------------
    // Wrap is the natural modulo of the width; no saturation.
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else if (inc_in) begin
            count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule : uhis_wrap_cnt

// >>> verif/uhis_monitor.sv
`include "uhis_defines.svh"

// Watches the top-level ports of the status block and flags protocol slips.
module uhis_monitor (
    // Clock and reset
    input wire logic                 MCLK_IN,
    input wire logic                 RST_IN,
    // Register access port
    input wire uhis_pkg::uhis_addr_t REG_ADDR_IN,
    input wire logic                 REG_WR_IN,
    input wire uhis_pkg::uhis_word_t REG_WDATA_IN,
    // Event sources
    input wire logic                 ROOT_CHANGE_IN,
    input wire logic                 SHARED_FRAME_UPD_IN,
    input wire logic                 SYS_ERROR_IN,
    input wire logic                 RESUME_SIG_IN,
    input wire logic                 SOF_TOKEN_IN,
    input wire logic                 DONE_WB_IN,
    input wire logic                 SCHED_OVERRUN_IN,
    input wire logic                 OWN_CHANGE_DONE_IN,
    // Requests and controls
    input wire logic                 IRQ_OUT,
    input wire logic                 HALT_OUT,
    input wire logic                 DONE_WB_ALLOW_OUT,
    input wire logic                 OWN_REQ_OUT,
    input wire logic [1:0]           OVERRUN_COUNT_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    import uhis_pkg::*;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);

    // Quiet means no source could set a flag; resume is counted while high, which is conservative.
    logic wr_st;
    logic quiet;
    assign wr_st = REG_WR_IN && (REG_ADDR_IN == `UHIS_OFS_EVT_STATUS);
    assign quiet = !(ROOT_CHANGE_IN | SHARED_FRAME_UPD_IN | SYS_ERROR_IN | RESUME_SIG_IN
                     | SOF_TOKEN_IN | DONE_WB_IN | SCHED_OVERRUN_IN);

    // A lone overrun keeps the lagging counter output free of overlapping increments.
    sequence s_lone_ovr;
        !SCHED_OVERRUN_IN ##1 SCHED_OVERRUN_IN ##1 !SCHED_OVERRUN_IN;
    endsequence
    sequence s_req_set;
        REG_WR_IN && REG_ADDR_IN == `UHIS_OFS_CMD_STATUS && REG_WDATA_IN[3] && !OWN_CHANGE_DONE_IN
        ##1 !OWN_CHANGE_DONE_IN;
    endsequence

    a_halt_on_error: assert property (SYS_ERROR_IN |=> HALT_OUT)
        else $error("halt missing after system error");
    a_halt_stays_set: assert property (HALT_OUT && !(wr_st && REG_WDATA_IN[4]) |=> HALT_OUT)
        else $error("fatal flag dropped without software clear");
    a_done_blocks_wb: assert property (DONE_WB_IN |=> !DONE_WB_ALLOW_OUT)
        else $error("writeback still allowed after done write");
    a_allow_on_clear: assert property (!DONE_WB_ALLOW_OUT && wr_st && REG_WDATA_IN[1] && !DONE_WB_IN
        |=> DONE_WB_ALLOW_OUT)
        else $error("writeback not reopened by flag clear");
    a_own_req_set: assert property (s_req_set |=> OWN_REQ_OUT)
        else $error("ownership request not shown");
    a_overrun_counts: assert property (s_lone_ovr |=>
        OVERRUN_COUNT_OUT == $past(OVERRUN_COUNT_OUT, 2) + 2'd1)
        else $error("overrun counter did not step by one");
    // An enable write lands one edge before the request can follow it, so look two edges back too.
    a_irq_has_cause: assert property ($rose(IRQ_OUT) |->
        $past(REG_WR_IN || !quiet) || $past(REG_WR_IN, 2))
        else $error("interrupt rose without a cause");
    a_irq_clear_all: assert property (wr_st && (REG_WDATA_IN & 32'h4000_007F) == 32'h4000_007F
        && quiet |=> !IRQ_OUT)
        else $error("interrupt held after all flags cleared");
endmodule : uhis_monitor

// >>> verif/uhis_host_model.sv
// Driver software seen from the pins: one strobed register access at a time.
module uhis_host_model (
    // Clock
    input wire logic                 MCLK_IN,
    // Register access port
    output uhis_pkg::uhis_addr_t     REG_ADDR_OUT,
    output logic                     REG_WR_OUT,
    output uhis_pkg::uhis_word_t     REG_WDATA_OUT,
    output logic                     REG_RD_OUT,
    input wire uhis_pkg::uhis_word_t REG_RDATA_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    import uhis_pkg::*;

    // Idle bus at time zero.
    initial begin
        REG_ADDR_OUT = 8'h00;
        REG_WR_OUT = 1'b0;
        REG_WDATA_OUT = 32'h0000_0000;
        REG_RD_OUT = 1'b0;
    end

    // Released lines show the inverse so stale values never pass for live ones.
    task automatic wr(input uhis_addr_t a, input uhis_word_t d);
        @(posedge MCLK_IN);
        REG_ADDR_OUT <= a;
        REG_WDATA_OUT <= d; // Callers keep reserved positions at zero.
        REG_WR_OUT <= 1'b1;
        @(posedge MCLK_IN);
        REG_WR_OUT <= 1'b0;
        REG_ADDR_OUT <= ~a;
        REG_WDATA_OUT <= ~d;
    endtask : wr

    // Read data lands on the same edge that takes the strobe.
    task automatic rd(input uhis_addr_t a, output uhis_word_t d);
        @(posedge MCLK_IN);
        REG_ADDR_OUT <= a;
        REG_RD_OUT <= 1'b1;
        @(posedge MCLK_IN);
        REG_RD_OUT <= 1'b0;
        REG_ADDR_OUT <= ~a;
        @(negedge MCLK_IN);
        d = REG_RDATA_IN;
    endtask : rd
endmodule : uhis_host_model

// >>> verif/uhis_top_tb.sv
// Self-checking bench for the event status block.
module uhis_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uhis_pkg::*;

    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [9:0] ev_q = 10'h000;
    uhis_addr_t addr;
    uhis_word_t wdata;
    uhis_word_t rdata;
    logic       wr, rd, irq, smi, halt, allow, own_req;
    logic [1:0] ovr_cnt;
    int         mismatches = 0;
    int         compares = 0;

    // Free-running controller clock.
    always #5 mclk = ~mclk;

    uhis_host_model host_u (.MCLK_IN(mclk), .REG_ADDR_OUT(addr), .REG_WR_OUT(wr), .REG_WDATA_OUT(wdata),
        .REG_RD_OUT(rd), .REG_RDATA_IN(rdata));
    uhis_top dut_u (.MCLK_IN(mclk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata),
        .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .ROOT_CHANGE_IN(ev_q[0]), .FRAME_MSB_IN(ev_q[1]),
        .SHARED_FRAME_UPD_IN(ev_q[2]), .SYS_ERROR_IN(ev_q[3]), .RESUME_SIG_IN(ev_q[4]),
        .RESUME_STATE_IN(ev_q[5]), .SOF_TOKEN_IN(ev_q[6]), .DONE_WB_IN(ev_q[7]),
        .SCHED_OVERRUN_IN(ev_q[8]), .OWN_CHANGE_DONE_IN(ev_q[9]), .IRQ_OUT(irq), .SMI_OUT(smi),
        .HALT_OUT(halt), .DONE_WB_ALLOW_OUT(allow), .OWN_REQ_OUT(own_req), .OVERRUN_COUNT_OUT(ovr_cnt));

    // --------------------------------------------------------------
    // Shared tasks.
    // --------------------------------------------------------------
    task automatic chk(input string nm, input uhis_word_t exp, input uhis_word_t got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rs(input uhis_addr_t a, input uhis_word_t exp, input string nm);
        uhis_word_t d;
        host_u.rd(a, d);
        chk(nm, exp, d);
    endtask : rs

    // One-cycle pulse on an event source.
    task automatic ev(input int i);
        @(posedge mclk) ev_q[i] <= 1'b1;
        @(posedge mclk) ev_q[i] <= 1'b0;
    endtask : ev

    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask : settle

    task automatic do_reset;
        @(posedge mclk) rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset

    // --------------------------------------------------------------
    // Scenarios.
    // --------------------------------------------------------------
    task automatic t_reset;
        rs(8'h0C, 32'h0000_0000, "status");
        rs(8'h08, 32'h0000_0000, "command");
        rs(8'h20, 32'h0000_0000, "unmapped");
        chk("allow", 32'h0000_0001, 32'(allow));
    endtask : t_reset

    task automatic t_flags;
        int src [4] = '{0, 6, 7, 3};
        int pos [4] = '{6, 2, 1, 4};
        uhis_word_t e = 32'h0000_0000;
        foreach (src[i]) begin
            ev(src[i]);
            e[pos[i]] = 1'b1;
            rs(8'h0C, e, "status");
        end
        ev(7);
        repeat (5) @(posedge mclk);
        rs(8'h0C, e, "sticky");
        chk("halt", 32'h0000_0001, 32'(halt));
        chk("allow", 32'h0000_0000, 32'(allow));
        host_u.wr(8'h0C, 32'h0000_0000);
        rs(8'h0C, e, "zero write");
        // Done head is taken as saved before its flag is cleared.
        host_u.wr(8'h0C, 32'h0000_0042);
        rs(8'h0C, 32'h0000_0014, "w1c");
        chk("allow", 32'h0000_0001, 32'(allow));
        do_reset(); // Fatal flag is cleared only after a controller reset.
        host_u.wr(8'h0C, 32'h0000_0010);
        host_u.wr(8'h0C, 32'h4000_007F);
        rs(8'h0C, 32'h0000_0000, "no set");
    endtask : t_flags

    task automatic t_frame;
        @(posedge mclk) ev_q[1] <= 1'b1;
        repeat (5) ev(8);
        rs(8'h0C, 32'h0000_0000, "before update");
        ev(2);
        rs(8'h0C, 32'h0000_0021, "frame flags");
        rs(8'h08, 32'h0001_0000, "overrun field");
        chk("overrun count", 32'h0000_0001, 32'(ovr_cnt));
        @(posedge mclk) ev_q[1] <= 1'b0;
        host_u.wr(8'h0C, 32'h4000_007F);
    endtask : t_frame

    task automatic t_resume;
        @(posedge mclk) ev_q[5] <= 1'b1;
        @(posedge mclk) ev_q[4] <= 1'b1;
        settle();
        rs(8'h0C, 32'h0000_0000, "own resume");
        @(posedge mclk) ev_q[5:4] <= 2'b00;
        @(posedge mclk) ev_q[4] <= 1'b1;
        settle();
        rs(8'h0C, 32'h0000_0008, "resume seen");
        @(posedge mclk) ev_q[4] <= 1'b0;
        host_u.wr(8'h0C, 32'h4000_007F);
    endtask : t_resume

    task automatic t_irq;
        host_u.wr(8'h10, 32'h0000_0004);
        ev(6);
        settle();
        chk("irq no global", 32'h0000_0000, 32'(irq));
        host_u.wr(8'h10, 32'h8000_0000);
        settle();
        chk("irq on", 32'h0000_0001, 32'(irq));
        rs(8'h10, 32'h8000_0004, "enable");
        host_u.wr(8'h14, 32'h0000_0004);
        settle();
        chk("irq masked", 32'h0000_0000, 32'(irq));
        host_u.wr(8'h10, 32'h0000_0004);
        host_u.wr(8'h0C, 32'h4000_007F);
        @(negedge mclk);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        host_u.wr(8'h14, 32'hC000_007F);
    endtask : t_irq

    task automatic t_own;
        host_u.wr(8'h10, 32'h4000_0000);
        host_u.wr(8'h08, 32'h0000_0008);
        settle();
        chk("own req", 32'h0000_0001, 32'(own_req));
        chk("smi", 32'h0000_0001, 32'(smi));
        ev(9);
        settle();
        chk("own req done", 32'h0000_0000, 32'(own_req));
        rs(8'h0C, 32'h4000_0000, "own flag");
        host_u.wr(8'h0C, 32'h4000_0000);
        settle();
        chk("smi cleared", 32'h0000_0000, 32'(smi));
    endtask : t_own

    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Main sequence.
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_flags();
        t_frame();
        t_resume();
        t_irq();
        t_own();
        stop_test();
    end

    // The whole sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        stop_test();
    end
endmodule : uhis_top_tb

bind uhis_top uhis_monitor mon_u (.*);
